//--- rtl/dual_halfword_mul.sv
`timescale 1ns/10ps
module dual_halfword_mul import smac_pkg::*; (
  // operands
  input  wire logic [31:0] first_operand_i,
  input  wire logic [31:0] second_operand_i,
  input  wire logic        swap_i,
  // products: lane 0 uses the bottom half of the first operand
  output logic [31:0]      prod_low_o,
  output logic [31:0]      prod_high_o
);

  logic [31:0] prod [2];

  for (genvar g = 0; g < 2; g++) begin : g_lane
    logic signed [15:0] a;
    logic signed [15:0] b;
    assign a = first_operand_i[16*g +: 16];
    assign b = swap_i ? second_operand_i[16*(1-g) +: 16] : second_operand_i[16*g +: 16];
    // a 16x16 signed product always fits 32 bits
    assign prod[g] = 32'(a) * 32'(b);
  end

  assign prod_low_o  = prod[0];
  assign prod_high_o = prod[1];

endmodule

//--- rtl/high_word_mul.sv
`timescale 1ns/10ps
module high_word_mul import smac_pkg::*; (
  // operands
  input  wire logic [31:0] first_operand_i,
  input  wire logic [31:0] second_operand_i,
  input  wire logic [31:0] acc_i,
  input  wire logic        round_i,
  input  wire hw_mode_t    mode_i,
  // full 64-bit sum, upper word is the answer
  output logic [63:0]      full_o
);

  logic signed [63:0] a;
  logic signed [63:0] b;
  logic [63:0]        prod;
  logic [63:0]        base;
  logic [63:0]        rnd;

  assign a    = {{32{first_operand_i[31]}}, first_operand_i};
  assign b    = {{32{second_operand_i[31]}}, second_operand_i};
  assign prod = 64'(a * b);
  assign base = (mode_i == HW_PLAIN) ? 64'h0 : {acc_i, 32'h0};
  assign rnd  = round_i ? ROUND_CONST : 64'h0;
  assign full_o = ((mode_i == HW_SUB) ? base - prod : base + prod) + rnd;

endmodule

//--- rtl/signed_mac_unit.sv
// What this block does
// - dual multiply-subtract, plus accumulate, to destination
// - long dual multiply-subtract into register pair
// - exchange swaps second operand's halfword pairing
// - saturation flag on accumulate overflow
// - rounding adds constant, otherwise truncate
// - high word product plus accumulate operand
// - accumulate operand minus high word product
// - plain high word signed product
// - dual multiply-add sums both halfword products
// - dual multiply-add overflow sets saturation
// - dual multiply-subtract, bottom product minus top
// - condition flags never changed by operations
// - halfword product sign-extended into register pair
// - long dual multiply-accumulate into register pair
`timescale 1ns/10ps
module signed_mac_unit import smac_pkg::*; (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // wishbone slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic [31:0]      dat_o,
  output logic             ack_o,
  // interrupt
  output logic             irq_o
);

  typedef struct packed {
    logic        ack;
    logic [31:0] rdata;
    logic        irq;
    logic [31:0] first;
    logic [31:0] second;
    logic [31:0] acc;
    logic [31:0] low;
    logic [31:0] high;
    logic [31:0] result;
    op_t         op;
    logic        swap;
    logic        round;
    logic        busy;
    logic [3:0]  nzcv;
    logic        sat;
    logic [1:0]  ists;
    logic [1:0]  imask;
  } state_t;

  localparam state_t STATE_RST = '{
    ack:    1'b0,
    rdata:  WORD_RST,
    irq:    1'b0,
    first:  WORD_RST,
    second: WORD_RST,
    acc:    WORD_RST,
    low:    WORD_RST,
    high:   WORD_RST,
    result: WORD_RST,
    op:     DUAL_MUL_ADD,
    swap:   1'b0,
    round:  1'b0,
    busy:   1'b0,
    nzcv:   NZCV_RST,
    sat:    1'b0,
    ists:   IRQ_RST,
    imask:  IRQ_RST
  };

  state_t      s;
  state_t      next_s;

  logic [31:0] prod_low;
  logic [31:0] prod_high;
  logic [63:0] hw_full;
  logic        mul_swap;
  hw_mode_t    hw_mode;

  logic        wr;
  logic [31:0] rd;
  logic [63:0] t64;
  logic [63:0] pair;
  logic        sat_ev;
  logic        done_ev;
  logic [1:0]  irq_clr;
  logic [31:0] flags_word;

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0]  be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic [63:0] sext(input logic [31:0] v);
    return {{32{v[31]}}, v};
  endfunction

  // true when a 64-bit sum still fits a signed word
  function automatic logic fits_word(input logic [63:0] v);
    return (v[63:31] == {33{1'b0}}) || (v[63:31] == {33{1'b1}});
  endfunction

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    return a[7:2] == ofs[7:2];
  endfunction

  // halfword long forms reuse the exchanged lanes
  assign mul_swap = s.swap || (s.op == LONG_HALF_MUL_ACC_BT) ||
                    (s.op == LONG_HALF_MUL_ACC_TB);

  always_comb begin
    unique case (s.op)
      HIGH_WORD_MUL_ACC: hw_mode = HW_ACC;
      HIGH_WORD_MUL_SUB: hw_mode = HW_SUB;
      default:           hw_mode = HW_PLAIN;
    endcase
  end

  dual_halfword_mul u_dual (
    .first_operand_i  (s.first),
    .second_operand_i (s.second),
    .swap_i           (mul_swap),
    .prod_low_o       (prod_low),
    .prod_high_o      (prod_high)
  );

  high_word_mul u_high (
    .first_operand_i  (s.first),
    .second_operand_i (s.second),
    .acc_i            (s.acc),
    .round_i          (s.round),
    .mode_i           (hw_mode),
    .full_o           (hw_full)
  );

  assign flags_word = {27'h0, s.sat, s.nzcv};
  assign pair       = {s.high, s.low};

  always_comb begin
    next_s  = s;
    t64     = 64'h0;
    sat_ev  = 1'b0;
    done_ev = 1'b0;
    irq_clr = 2'h0;
    rd      = 32'h0;

    // one answer per request, ack drops after one cycle
    next_s.ack = cyc_i && stb_i && !s.ack;
    // writes land on the edge where the master sees ack
    wr = cyc_i && stb_i && we_i && s.ack;

    // read mux; unmapped words read zero
    if (hit(adr_i, FIRST_OFS)) begin
      rd = s.first;
    end else if (hit(adr_i, SECOND_OFS)) begin
      rd = s.second;
    end else if (hit(adr_i, ACC_OFS)) begin
      rd = s.acc;
    end else if (hit(adr_i, LOW_OFS)) begin
      rd = s.low;
    end else if (hit(adr_i, HIGH_OFS)) begin
      rd = s.high;
    end else if (hit(adr_i, CMD_OFS)) begin
      rd = {23'h0, s.busy, 2'h0, s.round, s.swap, s.op};
    end else if (hit(adr_i, RESULT_OFS)) begin
      rd = s.result;
    end else if (hit(adr_i, FLAGS_OFS)) begin
      rd = flags_word;
    end else if (hit(adr_i, ISTS_OFS)) begin
      rd = {30'h0, s.ists};
    end else if (hit(adr_i, IMASK_OFS)) begin
      rd = {30'h0, s.imask};
    end
    next_s.rdata = next_s.ack ? rd : 32'h0;

    // execute one cycle after the command is taken
    if (s.busy) begin
      next_s.busy = 1'b0;
      done_ev     = 1'b1;
      unique case (s.op)
        DUAL_MUL_ADD: begin
          t64           = sext(prod_low) + sext(prod_high);
          next_s.result = t64[31:0];
          sat_ev        = !fits_word(t64);
        end
        DUAL_MUL_SUB: begin
          t64           = sext(prod_low) - sext(prod_high);
          next_s.result = t64[31:0];
        end
        DUAL_MUL_SUB_ACC: begin
          t64           = sext(prod_low) - sext(prod_high) + sext(s.acc);
          next_s.result = t64[31:0];
          sat_ev        = !fits_word(t64);
        end
        LONG_DUAL_MUL_SUB_ACC: begin
          t64         = pair + sext(prod_low) - sext(prod_high);
          next_s.high = t64[63:32];
          next_s.low  = t64[31:0];
        end
        HIGH_WORD_MUL, HIGH_WORD_MUL_ACC, HIGH_WORD_MUL_SUB: begin
          t64           = hw_full;
          next_s.result = t64[63:32];
        end
        LONG_HALF_MUL_ACC_BT: begin
          t64         = pair + sext(prod_low);
          next_s.high = t64[63:32];
          next_s.low  = t64[31:0];
        end
        LONG_HALF_MUL_ACC_TB: begin
          t64         = pair + sext(prod_high);
          next_s.high = t64[63:32];
          next_s.low  = t64[31:0];
        end
        LONG_DUAL_MUL_ACC: begin
          t64         = pair + sext(prod_low) + sext(prod_high);
          next_s.high = t64[63:32];
          next_s.low  = t64[31:0];
        end
        default: begin
          // undefined opcode: nothing written, no done event
          done_ev = 1'b0;
        end
      endcase
    end

    // register writes from software
    if (wr) begin
      if (hit(adr_i, FIRST_OFS)) begin
        next_s.first = merge(s.first, dat_i, sel_i);
      end else if (hit(adr_i, SECOND_OFS)) begin
        next_s.second = merge(s.second, dat_i, sel_i);
      end else if (hit(adr_i, ACC_OFS)) begin
        next_s.acc = merge(s.acc, dat_i, sel_i);
      end else if (hit(adr_i, LOW_OFS)) begin
        next_s.low = merge(s.low, dat_i, sel_i);
      end else if (hit(adr_i, HIGH_OFS)) begin
        next_s.high = merge(s.high, dat_i, sel_i);
      end else if (hit(adr_i, CMD_OFS) && sel_i[0]) begin
        // a command without its low byte lane is ignored
        next_s.op    = op_t'(dat_i[CMD_OP_LSB +: 4]);
        next_s.swap  = dat_i[CMD_SWAP_BIT];
        next_s.round = dat_i[CMD_ROUND_BIT];
        next_s.busy  = 1'b1;
      end else if (hit(adr_i, FLAGS_OFS) && sel_i[0]) begin
        next_s.nzcv = dat_i[3:0];
        next_s.sat  = dat_i[FLAGS_SAT_BIT];
      end else if (hit(adr_i, ISTS_OFS) && sel_i[0]) begin
        irq_clr = dat_i[1:0];
      end else if (hit(adr_i, IMASK_OFS) && sel_i[0]) begin
        next_s.imask = dat_i[1:0];
      end
    end

    // sticky, set beats a software clear
    if (sat_ev) begin
      next_s.sat = 1'b1;
    end
    // nzcv only changes by software write

    // events win over a write-one clear in the same cycle
    next_s.ists = (s.ists & ~irq_clr) |
                  {sat_ev, done_ev};
    next_s.irq  = |(next_s.ists & next_s.imask);
  end

  // operands arrive by value, register names unseen
  // pair held here as two distinct words
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s <= STATE_RST;
    end else begin
      s <= next_s;
    end
  end

  assign ack_o = s.ack;
  assign dat_o = s.rdata;
  assign irq_o = s.irq;

endmodule

//--- rtl/smac_pkg.sv
package smac_pkg;

  // register byte offsets, one aligned word each
  localparam logic [7:0] FIRST_OFS  = 8'h00;
  localparam logic [7:0] SECOND_OFS = 8'h04;
  localparam logic [7:0] ACC_OFS    = 8'h08;
  localparam logic [7:0] LOW_OFS    = 8'h0c;
  localparam logic [7:0] HIGH_OFS   = 8'h10;
  localparam logic [7:0] CMD_OFS    = 8'h14;
  localparam logic [7:0] RESULT_OFS = 8'h18;
  localparam logic [7:0] FLAGS_OFS  = 8'h1c;
  localparam logic [7:0] ISTS_OFS   = 8'h20;
  localparam logic [7:0] IMASK_OFS  = 8'h24;

  // command word fields
  localparam int CMD_OP_LSB    = 0;
  localparam int CMD_SWAP_BIT  = 4;
  localparam int CMD_ROUND_BIT = 5;
  localparam int CMD_BUSY_BIT  = 8;

  // flags word fields: condition flags in [3:0], saturation at 4
  localparam int FLAGS_SAT_BIT = 4;

  // interrupt status and mask layout
  localparam int IRQ_DONE_BIT = 0;
  localparam int IRQ_SAT_BIT  = 1;

  // reset values
  localparam logic [31:0] WORD_RST  = 32'h0000_0000;
  localparam logic [3:0]  NZCV_RST  = 4'h0;
  localparam logic [1:0]  IRQ_RST   = 2'h0;

  localparam logic [63:0] ROUND_CONST = 64'h0000_0000_8000_0000;

  typedef enum logic [3:0] {
    DUAL_MUL_ADD          = 4'b0000,
    DUAL_MUL_SUB          = 4'b0001,
    DUAL_MUL_SUB_ACC      = 4'b0010,
    LONG_DUAL_MUL_SUB_ACC = 4'b0011,
    HIGH_WORD_MUL         = 4'b0100,
    HIGH_WORD_MUL_ACC     = 4'b0101,
    HIGH_WORD_MUL_SUB     = 4'b0110,
    LONG_HALF_MUL_ACC_BT  = 4'b0111,
    LONG_HALF_MUL_ACC_TB  = 4'b1000,
    LONG_DUAL_MUL_ACC     = 4'b1001
  } op_t;

  typedef enum logic [1:0] {
    HW_PLAIN = 2'b00,
    HW_ACC   = 2'b01,
    HW_SUB   = 2'b10
  } hw_mode_t;

endpackage

//--- verif/signed_mac_unit_tb.sv
`timescale 1ns/10ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin miscompares++; \
  $display("Error %s expected %h seen %h", nm, e, g); end end
module signed_mac_unit_tb;
  import smac_pkg::*;
  logic        clk_i, rst_i, cyc, stb, we, ack, irq, sat_exp;
  logic [7:0]  adr;
  logic [3:0]  sel;
  logic [31:0] dw, dr, a, b, c, lo, hi, q;
  int          miscompares, n_checks;
  signed_mac_unit signed_mac_unit_inst (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb),
    .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(dw), .dat_o(dr), .ack_o(ack), .irq_o(irq));
  wb_issuer wb_issuer_inst (.clk_i(clk_i), .ack_i(ack), .dat_i(dr), .cyc_o(cyc), .stb_o(stb),
    .we_o(we), .adr_o(adr), .sel_o(sel), .dat_o(dw));
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    wb_issuer_inst.xfer(1'b1, ad, d, q);
  endtask
  task automatic rd(input logic [7:0] ad);
    wb_issuer_inst.xfer(1'b0, ad, 32'h0, q);
  endtask
  // rounding and accumulation kept at full 64-bit width
  function automatic logic [63:0] model(input logic [3:0] op, input logic sw, input logic rnd);
    logic [31:0]        b2;
    logic signed [63:0] p0, p1, pr, pair, rc;
    b2 = sw ? {b[15:0], b[31:16]} : b;
    p0 = $signed(a[15:0]) * $signed(b2[15:0]);
    p1 = $signed(a[31:16]) * $signed(b2[31:16]);
    pr = $signed(a) * $signed(b);
    pair = {hi, lo};
    rc = rnd ? ROUND_CONST : 64'h0;
    case (op)
      4'd0: model = p0 + p1;
      4'd1: model = p0 - p1;
      4'd2: model = p0 - p1 + $signed(c);
      4'd3: model = pair + p0 - p1;
      4'd4: model = (pr + rc) >> 32;
      4'd5: model = ({c, 32'h0} + pr + rc) >> 32;
      4'd6: model = ({c, 32'h0} - pr + rc) >> 32;
      4'd7: model = pair + $signed(a[15:0]) * $signed(b[31:16]);
      4'd8: model = pair + $signed(a[31:16]) * $signed(b[15:0]);
      default: model = pair + p0 + p1;
    endcase
  endfunction
  task automatic go(input logic [3:0] op, input logic sw, input logic rnd);
    logic [63:0] e;
    e = model(op, sw, rnd);
    if (op == 4'd0 || op == 4'd2) sat_exp |= (e[63:31] != '0 && e[63:31] != '1);
    wr(FIRST_OFS, a);
    wr(SECOND_OFS, b);
    wr(ACC_OFS, c);
    wr(LOW_OFS, lo);
    wr(HIGH_OFS, hi);
    wr(CMD_OFS, {26'h0, rnd, sw, op});
    if (op inside {4'd3, 4'd7, 4'd8, 4'd9}) begin
      rd(LOW_OFS);
      `CHK("pair low", e[31:0], q)
      rd(HIGH_OFS);
      `CHK("pair high", e[63:32], q)
    end else begin
      rd(RESULT_OFS);
      `CHK("result", e[31:0], q)
    end
    rd(FLAGS_OFS);
    `CHK("flags", {27'h0, sat_exp, 4'ha}, q)
  endtask
  task automatic t_reset();
    for (int i = 0; i < 11; i++) begin
      rd(8'(i * 4));
      `CHK("reset value", 32'h0, q)
    end
    wr(8'h28, 32'hffff_ffff);
    rd(8'h28);
    `CHK("unmapped", 32'h0, q)
    wr(FLAGS_OFS, 32'h0000_000a);
  endtask
  task automatic t_ops();
    for (int op = 0; op < 10; op++) begin
      for (int m = 0; m < 4; m++) begin
        go(4'(op), m[0], m[1]);
      end
    end
  endtask
  task automatic t_sat();
    // start from a clear flag, else the set is never seen
    wr(FLAGS_OFS, 32'h0000_000a);
    sat_exp = 1'b0;
    rd(FLAGS_OFS);
    `CHK("flags clear", 32'h0000_000a, q)
    {a, b, c} = {32'h8000_8000, 32'h8000_8000, 32'h0};
    go(4'd0, 1'b0, 1'b0);
    {a, b} = {32'h0001_0002, 32'h0003_0004};
    go(4'd1, 1'b1, 1'b0);
  endtask
  task automatic irq_is(input logic e);
    repeat (2) @(posedge clk_i);
    #1;
    `CHK("irq", e, irq)
  endtask
  task automatic t_irq();
    irq_is(1'b0);
    wr(IMASK_OFS, 32'h1);
    irq_is(1'b1);
    wr(ISTS_OFS, 32'h1);
    irq_is(1'b0);
    rd(ISTS_OFS);
    `CHK("status", 32'h2, q)
    wr(IMASK_OFS, 32'h2);
    irq_is(1'b1);
    wr(ISTS_OFS, 32'h2);
    irq_is(1'b0);
    go(4'd4, 1'b0, 1'b1);
    irq_is(1'b0);
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    rst_i = 1'b1;
    sat_exp = 1'b0;
    {a, b, c, lo, hi} = {32'h1234_fedc, 32'hff80_0123, 32'h8000_1000, 32'hffff_fff0, 32'h1};
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_reset();
    t_ops();
    {a, b, c, lo, hi} = {32'h4000_0000, 32'h0000_0003, 32'h7fff_ffff, 32'h7fff_ffff, 32'h0};
    t_ops();
    t_sat();
    t_irq();
    end_of_test();
  end
  initial begin
    repeat (40000) @(posedge clk_i);
    miscompares++;
    end_of_test();
  end
endmodule

//--- verif/smac_chk.sv
`timescale 1ns/10ps
module smac_chk (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // bus
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [31:0] dat_o,
  input  wire logic        ack_o,
  // interrupt
  input  wire logic        irq_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_ack_one_cycle: assert property (ack_o |=> !ack_o)
    else $error("ack held two cycles");
  a_ack_answers: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("request not answered next cycle");
  a_ack_cause: assert property (ack_o |-> $past(cyc_i && stb_i))
    else $error("ack without request");
  a_dat_idle: assert property (!ack_o |-> dat_o == 32'h0000_0000)
    else $error("read data outside ack");
  a_unmapped_zero: assert property (ack_o && !we_i && adr_i >= 8'h28 |-> dat_o == 32'h0)
    else $error("unmapped read not zero");
  a_irq_after_reset: assert property ($past(rst_i) |-> !irq_o)
    else $error("irq high after reset");
  a_irq_rise_cause: assert property ($rose(irq_o) |-> $past(ack_o && we_i)
    || $past(ack_o && we_i, 2)) else $error("irq rose without a write");
  a_irq_fall_cause: assert property ($fell(irq_o) |-> $past(ack_o && we_i)
    || $past(ack_o && we_i, 2)) else $error("irq fell without a write");
endmodule
bind signed_mac_unit smac_chk smac_chk_inst (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
  .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .dat_o(dat_o), .ack_o(ack_o), .irq_o(irq_o));

//--- verif/wb_issuer.sv
`timescale 1ns/10ps
module wb_issuer (
  // clock
  input  wire logic        clk_i,
  // slave answer
  input  wire logic        ack_i,
  input  wire logic [31:0] dat_i,
  // request
  output logic             cyc_o,
  output logic             stb_o,
  output logic             we_o,
  output logic [7:0]       adr_o,
  output logic [3:0]       sel_o,
  output logic [31:0]      dat_o
);
  initial begin
    {cyc_o, stb_o, we_o, adr_o, sel_o, dat_o} = '0;
  end
  // legal operand naming
  // only fixed offsets are issued, so no forbidden or aliased register can be named
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    @(posedge clk_i);
    cyc_o <= 1'b1;
    stb_o <= 1'b1;
    we_o  <= w;
    adr_o <= a;
    sel_o <= 4'hf;
    dat_o <= d;
    @(posedge clk_i iff (ack_i === 1'b1));
    q = dat_i;
    cyc_o <= 1'b0;
    stb_o <= 1'b0;
    we_o  <= 1'b0;
    // released data must not keep looking valid
    dat_o <= ~d;
  endtask
endmodule
